/* File: rtl/energy_pulse_output_logic.sv */
`include "meter_defs.svh"

module energy_pulse_output_logic #(
  parameter int E_PULSE_CYCLES = `E_PULSE_MS * 40000
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                sample_valid,
  input  wire meter_pkg::sample_t  cur_sample,
  input  wire meter_pkg::sample_t  volt_sample,
  input  wire logic                cal_freq_select,
  input  wire logic                freq_scale_sel_hi,
  input  wire logic                freq_scale_sel_lo,
  input  wire logic                gain_sel_hi,
  input  wire logic                gain_sel_lo,
  input  wire logic                highpass_enable_in,
  input  wire meter_pkg::reg_addr_t reg_addr,
  input  wire meter_pkg::reg_data_t reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output meter_pkg::reg_data_t     reg_rdata,
  output logic                     irq,
  output logic                     calibration_pulse_out,
  output logic                     energy_pulse_a,
  output logic                     energy_pulse_b,
  output logic                     negative_power_flag
);
  import meter_pkg::*;

  localparam int CAL_CYC =
    (`CAL_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // ========================================================
  // Pin synchronisers
  logic [5:0] pins;
  logic [5:0] sy1;
  logic [5:0] sy2;
  logic [5:0] sy3;
  logic [5:0] sel_q;

  assign pins = {cal_freq_select, freq_scale_sel_hi,
                 freq_scale_sel_lo, gain_sel_hi, gain_sel_lo,
                 highpass_enable_in};

  for (genvar g = 0; g < 6; g++) begin : g_sync
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        sy1[g]   <= 1'b0;
        sy2[g]   <= 1'b0;
        sy3[g]   <= 1'b0;
        sel_q[g] <= 1'b0;
      end else begin
        sy1[g] <= pins[g];
        sy2[g] <= sy1[g];
        sy3[g] <= sy2[g];
        if (sy2[g] == sy3[g]) begin
          sel_q[g] <= sy3[g];
        end
      end
    end
  end

  logic       hpf_on;
  logic       cal_sel;
  logic [1:0] gain_code;
  logic [1:0] scale_code;
  assign hpf_on     = sel_q[0];
  assign gain_code  = sel_q[2:1];
  assign scale_code = sel_q[4:3];
  assign cal_sel    = sel_q[5];

  // ========================================================
  // Decoded gain and thresholds
  logic [2:0] gain_shift;
  acc_t       energy_th;
  acc_t       cal_th;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gain_shift <= 3'h0;
      energy_th  <= `E_TH_BASE;
      cal_th     <= `E_TH_BASE >> `CAL_SHIFT_LO;
    end else begin
      unique case (gain_code)
        2'h0: gain_shift <= 3'h0;
        2'h1: gain_shift <= 3'h1;
        2'h2: gain_shift <= 3'h3;
        2'h3: gain_shift <= 3'h4;
      endcase
      energy_th <= `E_TH_BASE >> scale_code;
      cal_th    <= cal_sel ? (energy_th >> `CAL_SHIFT_HI)
                           : (energy_th >> `CAL_SHIFT_LO);
    end
  end

  // ========================================================
  // Datapath: gain, high-pass, phase correction, multiply
  logic               va;
  logic               vb;
  logic               vc;
  logic signed [20:0] gained;
  logic signed [20:0] dc_est;
  logic signed [20:0] hp;
  logic signed [20:0] hp_prev;
  logic signed [20:0] pc;
  logic signed [21:0] hdiff;
  logic signed [21:0] pdiff;
  sample_t            v_a;
  sample_t            v_b;
  logic signed [36:0] inst_pow;
  logic signed [36:0] avg_pow;
  logic signed [37:0] adiff;

  assign hdiff = 22'(gained) - 22'(dc_est);
  assign pdiff = 22'(hp) - 22'(hp_prev);
  assign adiff = 38'(inst_pow) - 38'(avg_pow);

  always_comb begin
    pc = hp;
    if (hpf_on) begin
      pc = hp - 21'(pdiff >>> `PC_SHIFT);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      va       <= 1'b0;
      vb       <= 1'b0;
      vc       <= 1'b0;
      gained   <= '0;
      dc_est   <= '0;
      hp       <= '0;
      hp_prev  <= '0;
      v_a      <= '0;
      v_b      <= '0;
      inst_pow <= '0;
      avg_pow  <= '0;
    end else begin
      va <= sample_valid;
      vb <= va;
      vc <= vb;
      if (sample_valid) begin
        gained <= 21'(cur_sample) <<< gain_shift;
        v_a    <= volt_sample;
      end
      if (va) begin
        dc_est <= dc_est + 21'(hdiff >>> `HPF_SHIFT);
        hp     <= hpf_on ? 21'(hdiff) : gained;
        v_b    <= v_a;
      end
      if (vb) begin
        hp_prev  <= hp;
        inst_pow <= pc * v_b;
      end
      if (vc) begin
        avg_pow <= avg_pow + 37'(adiff >>> `LPF_SHIFT);
      end
    end
  end

  // ========================================================
  // Pulse accumulators
  logic out_en;
  acc_t cal_acc;
  acc_t e_acc;
  logic cal_pos;
  logic cal_neg;
  logic cal_fire;
  logic e_pos;
  logic e_neg;
  logic e_fire;
  logic e_phase;

  assign cal_pos  = cal_acc >= cal_th;
  assign cal_neg  = cal_acc <= -cal_th;
  assign cal_fire = (cal_pos | cal_neg) & out_en
                    & ~calibration_pulse_out;
  assign e_pos    = e_acc >= energy_th;
  assign e_neg    = e_acc <= -energy_th;
  assign e_fire   = (e_pos | e_neg) & out_en
                    & ~energy_pulse_a & ~energy_pulse_b;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cal_acc <= '0;
      e_acc   <= '0;
    end else begin
      cal_acc <= cal_acc
               + (vc ? 48'(inst_pow) : '0)
               - (cal_fire & cal_pos ? cal_th : '0)
               + (cal_fire & cal_neg ? cal_th : '0);
      e_acc   <= e_acc
               + (vc ? 48'(avg_pow) : '0)
               - (e_fire & e_pos ? energy_th : '0)
               + (e_fire & e_neg ? energy_th : '0);
    end
  end

  // ========================================================
  // Direction flag and energy phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      negative_power_flag <= 1'b0;
    end else if (cal_fire) begin
      negative_power_flag <= cal_neg;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      e_phase <= 1'b0;
    end else if (e_fire) begin
      e_phase <= ~e_phase;
    end
  end

  // ========================================================
  // Pulse outputs
  pulse_stretch #(.WIDTH_CYCLES(CAL_CYC)) u_cal (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trig     (cal_fire),
    .pulse    (calibration_pulse_out)
  );

  pulse_stretch #(.WIDTH_CYCLES(E_PULSE_CYCLES)) u_ea (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trig     (e_fire & ~e_phase),
    .pulse    (energy_pulse_a)
  );

  pulse_stretch #(.WIDTH_CYCLES(E_PULSE_CYCLES)) u_eb (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trig     (e_fire & e_phase),
    .pulse    (energy_pulse_b)
  );

  // ========================================================
  // Registers and interrupt
  logic [2:0]  status;
  logic [2:0]  int_en;
  logic [2:0]  events;
  logic [2:0]  clr_mask;
  logic [31:0] cal_cnt;
  logic        dir_chg;

  assign dir_chg  = cal_fire & (cal_neg != negative_power_flag);
  assign events   = {dir_chg, e_fire, cal_fire};
  assign clr_mask = (reg_wr && reg_addr == `OFS_INT_CLR)
                    ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_en <= `CTRL_RST;
      int_en <= `INT_EN_RST;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_CTRL) begin
        out_en <= reg_wdata[`CTRL_OUT_EN];
      end
      if (reg_addr == `OFS_INT_EN) begin
        int_en <= reg_wdata[2:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status <= 3'h0;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~clr_mask) | events;
      irq    <= |(status & int_en);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cal_cnt <= '0;
    end else if (cal_fire) begin
      cal_cnt <= cal_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_CTRL:    reg_rdata <= {31'h0, out_en};
        `OFS_STATUS:  reg_rdata <= {29'h0, status};
        `OFS_INT_EN:  reg_rdata <= {29'h0, int_en};
        `OFS_STATE:   reg_rdata <= {25'h0, negative_power_flag,
                                    sel_q};
        `OFS_CAL_CNT: reg_rdata <= cal_cnt;
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_cal_fire;
    cal_fire;
  endsequence

  sequence s_cal_high;
    calibration_pulse_out [*8];
  endsequence

  sequence s_e_fire;
    e_fire;
  endsequence

  property p_cal_width;
    s_cal_fire |=> s_cal_high;
  endproperty
  a_cal_width: assert property (p_cal_width)
    else $error("Calibration pulse too short");

  property p_energy_pulse;
    s_e_fire |=> (energy_pulse_a ^ energy_pulse_b) [*8];
  endproperty
  a_energy_pulse: assert property (p_energy_pulse)
    else $error("Energy pulse not issued on one output");

  property p_flag_with_cal;
    $changed(negative_power_flag) |-> $rose(calibration_pulse_out);
  endproperty
  a_flag_with_cal: assert property (p_flag_with_cal)
    else $error("Direction flag moved without calibration pulse");

  property p_flag_neg;
    s_cal_fire ##0 cal_neg |=> negative_power_flag;
  endproperty
  a_flag_neg: assert property (p_flag_neg)
    else $error("Direction flag not set on negative power");

  property p_flag_pos;
    s_cal_fire ##0 cal_pos |=> !negative_power_flag;
  endproperty
  a_flag_pos: assert property (p_flag_pos)
    else $error("Direction flag not cleared on positive power");

  property p_gain;
    ##1 gain_shift == ($past(gain_code) == 2'h0 ? 3'h0 :
                       $past(gain_code) == 2'h1 ? 3'h1 :
                       $past(gain_code) == 2'h2 ? 3'h3 : 3'h4);
  endproperty
  a_gain: assert property (p_gain)
    else $error("Gain decode wrong");

  property p_scale;
    ##1 energy_th == (acc_t'(`E_TH_BASE) >> $past(scale_code));
  endproperty
  a_scale: assert property (p_scale)
    else $error("Scale threshold wrong");

  property p_cal_scale;
    ##1 cal_th == ($past(cal_sel)
                   ? ($past(energy_th) >> `CAL_SHIFT_HI)
                   : ($past(energy_th) >> `CAL_SHIFT_LO));
  endproperty
  a_cal_scale: assert property (p_cal_scale)
    else $error("Calibration scale wrong");

  property p_sync;
    $changed(sel_q) |-> sel_q == $past(sy3);
  endproperty
  a_sync: assert property (p_sync)
    else $error("Select changed before stages agreed");

  property p_bypass;
    va && !hpf_on |=> hp == $past(gained);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Filter not bypassed");

  property p_reset_clear;
    $rose(rstn) |-> $past(e_acc) == 0 && $past(avg_pow) == 0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Accumulators not cleared by reset");
endmodule

/* File: rtl/meter_defs.svh */
`ifndef METER_DEFS_SVH
`define METER_DEFS_SVH

// ==========================================================
// Register offsets
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_INT_EN    8'h08
`define OFS_INT_CLR   8'h0c
`define OFS_STATE     8'h10
`define OFS_CAL_CNT   8'h14

// ==========================================================
// Fields and reset values
`define CTRL_OUT_EN   0
`define ST_CAL       0
`define ST_ENERGY    1
`define ST_DIR       2
`define CTRL_RST      1'b1
`define INT_EN_RST    3'h0

// ==========================================================
// Datapath scaling
`define HPF_SHIFT     10
`define PC_SHIFT      6
`define LPF_SHIFT     12
`define E_TH_BASE     48'h0000_4000_0000
`define CAL_SHIFT_LO  6
`define CAL_SHIFT_HI  7

// ==========================================================
// Timing
`define CLK_PERIOD_NS 25
`define CAL_PULSE_NS  18000
`define E_PULSE_MS    100

`endif

/* File: rtl/meter_pkg.sv */
package meter_pkg;
  typedef logic signed [15:0] sample_t;
  typedef logic [7:0]         reg_addr_t;
  typedef logic [31:0]        reg_data_t;
  typedef logic signed [47:0] acc_t;
endpackage

/* File: rtl/pulse_stretch.sv */
module pulse_stretch #(
  parameter int WIDTH_CYCLES = 720
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic trig,
  output logic      pulse
);
  localparam int CW = $clog2(WIDTH_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(WIDTH_CYCLES - 1);

  logic [CW-1:0] cnt;

  // ========================================================
  // Fixed-width high pulse, triggers ignored while high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse <= 1'b0;
      cnt   <= '0;
    end else if (!pulse) begin
      pulse <= trig;
      cnt   <= '0;
    end else if (cnt == LAST) begin
      pulse <= 1'b0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

/* File: test/pulse_counter_model.sv */
module pulse_counter_model (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic energy_pulse_a,
  input  wire logic energy_pulse_b,
  output int        n_a,
  output int        n_b,
  output int        n_bad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pa;
  logic pb;
  logic last_b;
  // ==========================================
  // Two-phase stepper: phases alternate a, b
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pa <= 1'b0;
      pb <= 1'b0;
      last_b <= 1'b1;
      n_a <= 0;
      n_b <= 0;
      n_bad <= 0;
    end else begin
      pa <= energy_pulse_a;
      pb <= energy_pulse_b;
      if (energy_pulse_a && !pa) begin
        n_a <= n_a + 1;
        last_b <= 1'b0;
        if (!last_b) n_bad <= n_bad + 1;
      end
      if (energy_pulse_b && !pb) begin
        n_b <= n_b + 1;
        last_b <= 1'b1;
        if (last_b) n_bad <= n_bad + 1;
      end
      if (energy_pulse_a && energy_pulse_b) n_bad <= n_bad + 1;
    end
  end
endmodule

/* File: test/tb_energy_pulse_output_logic.sv */
`include "meter_defs.svh"
module tb_energy_pulse_output_logic;
  timeunit 1ns;
  timeprecision 100ps;
  import meter_pkg::*;
  localparam int EP = 16;
  logic      core_clk = 0, rstn = 0, sample_valid = 0;
  sample_t   cur_sample = '0, volt_sample = '0;
  logic      cal_freq_select = 0, freq_scale_sel_hi = 0;
  logic      freq_scale_sel_lo = 0, gain_sel_hi = 0, gain_sel_lo = 0;
  logic      highpass_enable_in = 0, reg_wr = 0, reg_rd = 0;
  reg_addr_t reg_addr = '0;
  reg_data_t reg_wdata = '0, reg_rdata, rd;
  logic      irq, calibration_pulse_out, energy_pulse_a, energy_pulse_b;
  logic      negative_power_flag, pf, pc;
  int        n_mismatch = 0, n_tests = 0, n_a, n_b, n_bad;
  int        w_cal = 0, w_ea = 0;

  initial forever #12.5 core_clk = ~core_clk;

  energy_pulse_output_logic #(.E_PULSE_CYCLES(EP))
    i_energy_pulse_output_logic (.core_clk, .rstn, .sample_valid,
    .cur_sample, .volt_sample, .cal_freq_select, .freq_scale_sel_hi,
    .freq_scale_sel_lo, .gain_sel_hi, .gain_sel_lo, .highpass_enable_in,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .calibration_pulse_out, .energy_pulse_a, .energy_pulse_b,
    .negative_power_flag);
  pulse_counter_model i_pulse_counter_model (.core_clk, .rstn,
    .energy_pulse_a, .energy_pulse_b, .n_a, .n_b, .n_bad);

  // ==========================================
  // Tasks
  task check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task wr(input reg_addr_t a, input reg_data_t d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
    repeat (2) @(negedge core_clk);
  endtask
  task rdreg(input reg_addr_t a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge core_clk);
    reg_rd <= 0;
    @(negedge core_clk);
    rd = reg_rdata;
  endtask
  task pins(input logic [5:0] p);
    @(posedge core_clk);
    {cal_freq_select, freq_scale_sel_hi, freq_scale_sel_lo, gain_sel_hi,
     gain_sel_lo, highpass_enable_in} <= p;
    repeat (6) @(posedge core_clk);
  endtask
  task feed(input sample_t c, v, input int n, gap);
    repeat (n) begin
      @(posedge core_clk);
      cur_sample <= c;
      volt_sample <= v;
      sample_valid <= 1;
      @(posedge core_clk);
      sample_valid <= 0;
      repeat (gap) @(posedge core_clk);
    end
  endtask
  task settle;
    int i;
    repeat (800) @(negedge core_clk);
    for (i = 0; i < 2000 && calibration_pulse_out !== 0; i++)
      @(negedge core_clk);
    if (i == 2000) begin
      n_mismatch++;
      final_report;
    end
  endtask
  task rate(input logic [5:0] p, input sample_t c, input int n, gap,
            output int kc, ke);
    pins(p);
    rdreg(`OFS_CAL_CNT);
    kc = rd;
    ke = n_a + n_b;
    feed(c, c, n, gap);
    settle;
    rdreg(`OFS_CAL_CNT);
    kc = rd - kc;
    ke = n_a + n_b - ke;
  endtask

  // ==========================================
  // Output monitors
  always @(negedge core_clk) begin
    if (rstn && negative_power_flag !== pf)
      check("flag_step", calibration_pulse_out & ~pc, 1);
    if (!rstn) begin
      w_cal = 0;
      w_ea = 0;
    end else begin
      if (calibration_pulse_out) w_cal++;
      else if (w_cal != 0) begin
        check("cal_width", w_cal, 720);
        w_cal = 0;
      end
      if (energy_pulse_a) w_ea++;
      else if (w_ea != 0) begin
        check("energy_width", w_ea, EP);
        w_ea = 0;
      end
    end
    pf = negative_power_flag;
    pc = calibration_pulse_out;
  end

  // ==========================================
  // Scenarios
  task t_reset;
    @(negedge core_clk);
    check("outs_idle", {irq, calibration_pulse_out, energy_pulse_a,
          energy_pulse_b, negative_power_flag}, 0);
    rdreg(`OFS_CTRL);
    check("ctrl_rst", rd, 1);
    @(negedge core_clk);
    check("rdata_idle", reg_rdata, 0);
    rdreg(`OFS_INT_EN);
    check("int_en_rst", rd, 0);
    rdreg(`OFS_CAL_CNT);
    check("cal_cnt_rst", rd, 0);
    rdreg(8'h20);
    check("unmapped", rd, 0);
  endtask
  task t_sel;
    logic [5:0] p;
    for (int i = 0; i < 8; i++) begin
      p = i < 6 ? 6'h01 << i : (i == 6 ? 6'h00 : 6'h3f);
      pins(p);
      rdreg(`OFS_STATE);
      check("sel_sync", rd[5:0], p);
    end
  endtask
  task t_irq;
    reg_data_t k;
    pins(6'h00);
    wr(`OFS_INT_CLR, 7);
    wr(`OFS_INT_EN, 1);
    feed(256, 256, 300, 0);
    settle;
    rdreg(`OFS_STATUS);
    check("status_cal", rd[0], 1);
    check("status_dir0", rd[2], 0);
    check("irq_on", irq, 1);
    wr(`OFS_INT_EN, 0);
    check("irq_masked", irq, 0);
    wr(`OFS_INT_EN, 1);
    check("irq_again", irq, 1);
    wr(`OFS_INT_CLR, 1);
    check("irq_cleared", irq, 0);
    wr(`OFS_CTRL, 0);
    rdreg(`OFS_CAL_CNT);
    k = rd;
    feed(256, 256, 300, 0);
    settle;
    rdreg(`OFS_CAL_CNT);
    check("gate_off", rd, k);
    wr(`OFS_CTRL, 1);
  endtask
  task t_rate;
    int kc[4];
    int ke[4];
    int kc_sel;
    for (int g = 0; g < 4; g++) begin
      rate(6'(g << 1), 256, 512, 14, kc[g], ke[0]);
      if (g == 0) rate(6'h20, 256, 512, 14, kc_sel, ke[1]);
    end
    check("gain_rate", kc[3] > kc[0] && kc[2] > kc[1] && kc[1] > kc[0],
          1);
    check("cal_sel_rate", kc_sel > kc[0], 1);
    for (int s = 0; s < 4; s++) rate(6'(s << 3), 1024, 4000, 0, kc[0], ke[s]);
    check("scale_rate", ke[3] > ke[2] && ke[2] > ke[1] && ke[1] > ke[0],
          1);
    check("ab_order", n_bad, 0);
    rdreg(`OFS_STATUS);
    check("status_energy", rd[1], 1);
  endtask
  task t_flag;
    pins(6'h00);
    feed(256, -256, 600, 0);
    settle;
    check("flag_neg", negative_power_flag, 1);
    rdreg(`OFS_STATUS);
    check("status_dir", rd[2], 1);
    rdreg(`OFS_STATE);
    check("state_flag", rd[6], 1);
    feed(256, 256, 600, 0);
    settle;
    check("flag_pos", negative_power_flag, 0);
  endtask
  task t_reset_mid;
    @(posedge core_clk);
    rstn <= 0;
    repeat (3) @(negedge core_clk);
    check("outs_reset", {irq, calibration_pulse_out, energy_pulse_a,
          energy_pulse_b, negative_power_flag}, 0);
    @(posedge core_clk);
    rstn <= 1;
    rdreg(`OFS_CAL_CNT);
    check("cal_cnt_clear", rd, 0);
    rdreg(`OFS_STATUS);
    check("status_clear", rd, 0);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1;
    repeat (2) @(posedge core_clk);
    t_reset;
    t_sel;
    t_irq;
    t_flag;
    t_rate;
    t_reset_mid;
    final_report;
  end
endmodule
